// [logic/osc_ctrl_pkg.sv]
// Constants, field layout and carrier types of the oscillator control registers
package osc_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFF_CLK_DIV = 8'h04;
    localparam logic [7:0] OFF_PLL_FB = 8'h08;
    localparam logic [7:0] OFF_RC_TUNE = 8'h0C;
    localparam logic [7:0] OFF_UNLOCK = 8'h10;
    // Oscillator control fields
    localparam int CUR_SRC_LSB = 12;
    localparam int NEW_SRC_LSB = 8;
    localparam int SW_LOCK_BIT = 7;
    localparam int PIN_LOCK_BIT = 6;
    localparam int PLL_LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int SEC_EN_BIT = 1;
    localparam int SW_REQ_BIT = 0;
    // Clock divisor fields
    localparam int RECOVER_BIT = 15;
    localparam int RATIO_LSB = 12;
    localparam int RED_EN_BIT = 11;
    localparam int RC_POST_LSB = 8;
    localparam int PLL_POST_LSB = 6;
    localparam int PLL_PRE_LSB = 0;
    // Reset values and the reserved PLL divider code
    localparam logic [2:0] SRC_RST = 3'h7;
    localparam logic [2:0] RATIO_RST = 3'h3;
    localparam logic [2:0] RC_POST_RST = 3'h0;
    localparam logic [1:0] PLL_POST_RST = 2'h1;
    localparam logic [1:0] PLL_POST_RSVD = 2'h2;
    localparam logic [4:0] PLL_PRE_RST = 5'h00;
    localparam logic [8:0] PLL_FB_RST = 9'h030;
    localparam logic [5:0] TRIM_RST = 6'h00;
    // Switch mode configuration
    localparam logic [1:0] MODE_SW_ONLY = 2'h1;
    localparam logic [1:0] MODE_SW_MON = 2'h0;
    // Unlock keys, values arbitrary
    localparam logic [15:0] UNLOCK_KEY_A = 16'h5A3C;
    localparam logic [15:0] UNLOCK_KEY_B = 16'hC3A5;
    // Strap capture point after reset release
    localparam logic [1:0] STRAP_CAPTURE = 2'h2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SRC_FAST_RC = 3'h0,
        SRC_FAST_RC_PLL = 3'h1,
        SRC_PRIMARY = 3'h2,
        SRC_PRIMARY_PLL = 3'h3,
        SRC_SECONDARY = 3'h4,
        SRC_LOW_POWER_RC = 3'h5,
        SRC_FAST_RC_DIV_SIXTEEN = 3'h6,
        SRC_FAST_RC_DIV_N = 3'h7
    } clk_src_t;

    typedef struct packed {
        logic [1:0] outDiv;
        logic [4:0] prescale;
        logic [8:0] feedback;
    } pll_cfg_t;

    typedef struct packed {
        logic [2:0] rcPostscale;
        logic [5:0] rcTrim;
    } rc_cfg_t;
endpackage

// [logic/clock_switch_engine.sv]
// Handshake sequencer that hands a new source to the clock multiplexer
`timescale 1ns/1ps
module clock_switch_engine (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [2:0] target,
    input wire logic muxAck,
    output logic busy,
    output logic done,
    output logic muxReq,
    output logic [2:0] muxTarget
);
    typedef enum logic [1:0] {IDLE, REQUEST, RELEASE, FINISH} sw_state_t;
    sw_state_t state_r;
    logic [2:0] target_r;
    logic req_r;
    logic done_r;

    // Four-phase handshake: ack high then low again before the switch counts
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= IDLE;
        end else begin
            unique case (state_r)
                IDLE: begin
                    if (start) begin
                        state_r <= REQUEST;
                    end
                end
                REQUEST: begin
                    if (muxAck) begin
                        state_r <= RELEASE;
                    end
                end
                RELEASE: begin
                    if (!muxAck) begin
                        state_r <= FINISH;
                    end
                end
                FINISH: begin
                    state_r <= IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            target_r <= 3'h0;
        end else if (state_r == IDLE && start) begin
            target_r <= target;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            req_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            req_r <= (state_r == IDLE && start) || (state_r == REQUEST && !muxAck);
            done_r <= (state_r == RELEASE && !muxAck);
        end
    end

    assign busy = (state_r != IDLE);
    assign done = done_r;
    assign muxReq = req_r;
    assign muxTarget = target_r;
endmodule

// [logic/osc_ctrl_regs.sv]
// Oscillator control register block with AXI4-Lite slave
// What this block does
// - Read-only current source field in bits 14:12, eight source encodings.
// - Writable new source field in bits 10:8 names the next switch target.
// - Writing one to the request bit switches; bit reads zero once complete.
// - In mode 01 the set-only lock bit freezes the clock source.
// - Pin map lock set rejects pin-mapping writes; clear accepts them.
// - PLL lock flag is one when locked or timer expired, and PLL enabled.
// - Monitor failure sets the fail flag; software reads or clears only.
// - Secondary oscillator enable bit, reset zero, drives the oscillator on.
// - Oscillator control writes are taken only after the unlock sequence.
// - All four registers reset only on power-on reset.
// - With recover set, an interrupt clears reduction enable, ratio 1:1.
// - Reduction ratio divides processor clock by two to the field; reset 011.
// - Reduction enable selects the ratio; otherwise ratio forced to 1:1.
// - Fast RC postscaler divides by 2^code, 128 at 111; reset 000.
// - PLL output divider 2, 4, 8; reset 01; code 10 reserved.
// - PLL input prescaler divides by field plus two; reset zero.
// - PLL feedback multiplier is field plus two; reset value 50.
// - Six-bit signed fast RC trim, 0.375% steps, reset zero.
// - Unimplemented bits read zero and ignore writes.
// - Both source fields load the configured initial source at power-on.
// - Mode 1x disables switching and monitor; 01 switching only; 00 both.
// - Instruction clock is the system clock divided by two.
`timescale 1ns/1ps
module osc_ctrl_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] initSourceCfg,
    input wire logic [1:0] clockSwitchModeCfg,
    input wire logic pllLockedIn,
    input wire logic pllTimerDoneIn,
    input wire logic clockFailIn,
    input wire logic muxAckIn,
    input wire logic irqEvent,
    input wire logic pinMapWrReq,
    output logic pinMapWrAccept,
    output logic [2:0] currentSource,
    output logic muxReq,
    output logic [2:0] muxTarget,
    output logic secondaryOscEnable,
    output logic pinMapLock,
    output osc_ctrl_pkg::pll_cfg_t pllCfg,
    output osc_ctrl_pkg::rc_cfg_t rcCfg,
    output logic instrTick,
    output logic procTick
);
    if (ADDR_W < 5 || ADDR_W > 32) begin : gBadAddrW
        $error("ADDR_W must lie between 5 and 32");
    end

    // Pin inputs: two flip-flops before use
    localparam int SYNC_W = 9;
    logic [SYNC_W-1:0] syncA_r;
    logic [SYNC_W-1:0] syncB_r;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= {initSourceCfg, clockSwitchModeCfg, pllLockedIn,
                pllTimerDoneIn, clockFailIn, muxAckIn};
            syncB_r <= syncA_r;
        end
    end
    logic [2:0] strapSrc;
    logic [1:0] mode;
    logic pllLocked;
    logic pllTimerDone;
    logic failSeen;
    logic muxAck;
    assign {strapSrc, mode, pllLocked, pllTimerDone, failSeen, muxAck} = syncB_r;

    logic switchAllowed;
    logic monitorOn;
    logic switchLock_r;
    // Mode 1x blocks all switching, the lock only counts in mode 01
    assign switchAllowed = !mode[1]
        && !(mode == osc_ctrl_pkg::MODE_SW_ONLY && switchLock_r);
    assign monitorOn = (mode == osc_ctrl_pkg::MODE_SW_MON);

    // Strap capture once the synchroniser has filled
    logic [1:0] loadCnt_r;
    logic strapLoad;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            loadCnt_r <= 2'h0;
        end else if (loadCnt_r != 2'h3) begin
            loadCnt_r <= loadCnt_r + 2'h1;
        end
    end
    assign strapLoad = (loadCnt_r == osc_ctrl_pkg::STRAP_CAPTURE);

    // AXI write channels
    logic awHeld_r;
    logic wHeld_r;
    logic awReady_r;
    logic wReady_r;
    logic bValid_r;
    logic [1:0] bResp_r;
    logic [7:0] awAddr_r;
    logic [15:0] wData_r;
    logic [1:0] wStrb_r;
    logic doWrite;
    assign doWrite = awHeld_r && wHeld_r && !bValid_r;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_r <= 1'b0;
            awReady_r <= 1'b1;
            awAddr_r <= 8'h00;
        end else if (awReady_r && s_axi_awvalid) begin
            awHeld_r <= 1'b1;
            awReady_r <= 1'b0;
            awAddr_r <= 8'(s_axi_awaddr);
        end else if (doWrite) begin
            awHeld_r <= 1'b0;
        end else if (bValid_r && s_axi_bready) begin
            awReady_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wHeld_r <= 1'b0;
            wReady_r <= 1'b1;
            wData_r <= 16'h0000;
            wStrb_r <= 2'h0;
        end else if (wReady_r && s_axi_wvalid) begin
            wHeld_r <= 1'b1;
            wReady_r <= 1'b0;
            wData_r <= s_axi_wdata[15:0];
            wStrb_r <= s_axi_wstrb[1:0];
        end else if (doWrite) begin
            wHeld_r <= 1'b0;
        end else if (bValid_r && s_axi_bready) begin
            wReady_r <= 1'b1;
        end
    end

    logic mapped;
    logic unlockArmed_r;
    logic [15:0] mask;
    logic wrOsc;
    logic wrDiv;
    logic wrFb;
    logic wrTune;
    logic wrKey;
    assign mapped = awAddr_r == osc_ctrl_pkg::OFF_OSC_CTRL || awAddr_r == osc_ctrl_pkg::OFF_CLK_DIV
        || awAddr_r == osc_ctrl_pkg::OFF_PLL_FB || awAddr_r == osc_ctrl_pkg::OFF_RC_TUNE
        || awAddr_r == osc_ctrl_pkg::OFF_UNLOCK;
    assign mask = {{8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
    assign wrOsc = doWrite && awAddr_r == osc_ctrl_pkg::OFF_OSC_CTRL && unlockArmed_r;
    assign wrDiv = doWrite && awAddr_r == osc_ctrl_pkg::OFF_CLK_DIV;
    assign wrFb = doWrite && awAddr_r == osc_ctrl_pkg::OFF_PLL_FB;
    assign wrTune = doWrite && awAddr_r == osc_ctrl_pkg::OFF_RC_TUNE;
    assign wrKey = doWrite && awAddr_r == osc_ctrl_pkg::OFF_UNLOCK && (&wStrb_r);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bValid_r <= 1'b0;
            bResp_r <= osc_ctrl_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bValid_r <= 1'b1;
            // Locked control write is refused visibly
            if (!mapped || (awAddr_r == osc_ctrl_pkg::OFF_OSC_CTRL && !unlockArmed_r)) begin
                bResp_r <= osc_ctrl_pkg::RESP_SLVERR;
            end else begin
                bResp_r <= osc_ctrl_pkg::RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            bValid_r <= 1'b0;
        end
    end

    // Two-key unlock; any other write disarms, so each control write needs a fresh pair
    logic keyStage_r;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            keyStage_r <= 1'b0;
            unlockArmed_r <= 1'b0;
        end else if (wrKey) begin
            keyStage_r <= (wData_r == osc_ctrl_pkg::UNLOCK_KEY_A);
            unlockArmed_r <= keyStage_r && (wData_r == osc_ctrl_pkg::UNLOCK_KEY_B);
        end else if (doWrite) begin
            keyStage_r <= 1'b0;
            unlockArmed_r <= 1'b0;
        end
    end

    // Oscillator control fields
    logic [2:0] curSrc_r;
    logic [2:0] newSrc_r;
    logic [2:0] newSrcWr;
    logic switchReq_r;
    logic pinLock_r;
    logic fail_r;
    logic failPrev_r;
    logic secEn_r;
    logic startSwitch;
    logic swBusy;
    logic swDone;
    logic pllOn;
    logic pllLockFlag;
    assign newSrcWr = mask[osc_ctrl_pkg::NEW_SRC_LSB] ? wData_r[osc_ctrl_pkg::NEW_SRC_LSB +: 3]
        : newSrc_r;
    assign startSwitch = wrOsc && mask[osc_ctrl_pkg::SW_REQ_BIT]
        && wData_r[osc_ctrl_pkg::SW_REQ_BIT] && switchAllowed && !switchReq_r && !swBusy;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            curSrc_r <= osc_ctrl_pkg::SRC_RST;
            newSrc_r <= osc_ctrl_pkg::SRC_RST;
        end else if (strapLoad) begin
            curSrc_r <= strapSrc;
            newSrc_r <= strapSrc;
        end else begin
            if (swDone) begin
                curSrc_r <= muxTarget;
            end
            if (wrOsc) begin
                newSrc_r <= newSrcWr;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            switchReq_r <= 1'b0;
        end else if (startSwitch) begin
            switchReq_r <= 1'b1;
        end else if (swDone) begin
            switchReq_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            switchLock_r <= 1'b0;
            pinLock_r <= 1'b0;
            secEn_r <= 1'b0;
        end else if (wrOsc && mask[0]) begin
            if (wData_r[osc_ctrl_pkg::SW_LOCK_BIT]) begin
                switchLock_r <= 1'b1;
            end
            pinLock_r <= wData_r[osc_ctrl_pkg::PIN_LOCK_BIT];
            secEn_r <= wData_r[osc_ctrl_pkg::SEC_EN_BIT];
        end
    end

    // Failure set beats a software clear in the same cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fail_r <= 1'b0;
            failPrev_r <= 1'b0;
        end else begin
            failPrev_r <= failSeen;
            if (monitorOn && failSeen && !failPrev_r) begin
                fail_r <= 1'b1;
            end else if (wrOsc && mask[0] && !wData_r[osc_ctrl_pkg::FAIL_BIT]) begin
                fail_r <= 1'b0;
            end
        end
    end

    assign pllOn = (curSrc_r == osc_ctrl_pkg::SRC_FAST_RC_PLL)
        || (curSrc_r == osc_ctrl_pkg::SRC_PRIMARY_PLL);
    assign pllLockFlag = pllOn && (pllLocked || pllTimerDone);

    clock_switch_engine u_switch (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(startSwitch),
        .target(newSrcWr),
        .muxAck(muxAck),
        .busy(swBusy),
        .done(swDone),
        .muxReq(muxReq),
        .muxTarget(muxTarget)
    );

    // Clock divisor fields
    logic recover_r;
    logic [2:0] ratio_r;
    logic redEn_r;
    logic [2:0] rcPost_r;
    logic [1:0] pllPost_r;
    logic [4:0] pllPre_r;
    logic [8:0] pllFb_r;
    logic [5:0] trim_r;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            recover_r <= 1'b0;
            ratio_r <= osc_ctrl_pkg::RATIO_RST;
            rcPost_r <= osc_ctrl_pkg::RC_POST_RST;
        end else if (wrDiv && mask[15]) begin
            recover_r <= wData_r[osc_ctrl_pkg::RECOVER_BIT];
            ratio_r <= wData_r[osc_ctrl_pkg::RATIO_LSB +: 3];
            rcPost_r <= wData_r[osc_ctrl_pkg::RC_POST_LSB +: 3];
        end
    end

    // Interrupt recovery wins over a software set in the same cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            redEn_r <= 1'b0;
        end else if (recover_r && irqEvent) begin
            redEn_r <= 1'b0;
        end else if (wrDiv && mask[15]) begin
            redEn_r <= wData_r[osc_ctrl_pkg::RED_EN_BIT];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pllPost_r <= osc_ctrl_pkg::PLL_POST_RST;
            pllPre_r <= osc_ctrl_pkg::PLL_PRE_RST;
        end else if (wrDiv && mask[0]) begin
            // Reserved divider code leaves the old setting in place
            if (wData_r[osc_ctrl_pkg::PLL_POST_LSB +: 2] != osc_ctrl_pkg::PLL_POST_RSVD) begin
                pllPost_r <= wData_r[osc_ctrl_pkg::PLL_POST_LSB +: 2];
            end
            pllPre_r <= wData_r[osc_ctrl_pkg::PLL_PRE_LSB +: 5];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pllFb_r <= osc_ctrl_pkg::PLL_FB_RST;
        end else if (wrFb) begin
            pllFb_r <= (pllFb_r & ~mask[8:0]) | (wData_r[8:0] & mask[8:0]);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            trim_r <= osc_ctrl_pkg::TRIM_RST;
        end else if (wrTune && mask[0]) begin
            trim_r <= wData_r[5:0];
        end
    end

    // Read path; holes stay zero
    logic [15:0] rdWord;
    logic [7:0] arAddr;
    assign arAddr = 8'(s_axi_araddr);
    always_comb begin
        rdWord = 16'h0000;
        unique case (arAddr)
            osc_ctrl_pkg::OFF_OSC_CTRL: begin
                rdWord[osc_ctrl_pkg::CUR_SRC_LSB +: 3] = curSrc_r;
                rdWord[osc_ctrl_pkg::NEW_SRC_LSB +: 3] = newSrc_r;
                rdWord[osc_ctrl_pkg::SW_LOCK_BIT] = switchLock_r;
                rdWord[osc_ctrl_pkg::PIN_LOCK_BIT] = pinLock_r;
                rdWord[osc_ctrl_pkg::PLL_LOCK_BIT] = pllLockFlag;
                rdWord[osc_ctrl_pkg::FAIL_BIT] = fail_r;
                rdWord[osc_ctrl_pkg::SEC_EN_BIT] = secEn_r;
                rdWord[osc_ctrl_pkg::SW_REQ_BIT] = switchReq_r;
            end
            osc_ctrl_pkg::OFF_CLK_DIV: begin
                rdWord = {recover_r, ratio_r, redEn_r, rcPost_r, pllPost_r, 1'b0, pllPre_r};
            end
            osc_ctrl_pkg::OFF_PLL_FB: begin
                rdWord = {7'h00, pllFb_r};
            end
            osc_ctrl_pkg::OFF_RC_TUNE: begin
                rdWord = {10'h000, trim_r};
            end
            osc_ctrl_pkg::OFF_UNLOCK: begin
                rdWord = {14'h0000, unlockArmed_r, keyStage_r};
            end
            default: begin
                rdWord = 16'h0000;
            end
        endcase
    end

    logic arReady_r;
    logic rValid_r;
    logic [15:0] rData_r;
    logic [1:0] rResp_r;
    logic rdMapped;
    assign rdMapped = arAddr == osc_ctrl_pkg::OFF_OSC_CTRL || arAddr == osc_ctrl_pkg::OFF_CLK_DIV
        || arAddr == osc_ctrl_pkg::OFF_PLL_FB || arAddr == osc_ctrl_pkg::OFF_RC_TUNE
        || arAddr == osc_ctrl_pkg::OFF_UNLOCK;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            arReady_r <= 1'b1;
            rValid_r <= 1'b0;
            rData_r <= 16'h0000;
            rResp_r <= osc_ctrl_pkg::RESP_OKAY;
        end else if (arReady_r && s_axi_arvalid) begin
            arReady_r <= 1'b0;
            rValid_r <= 1'b1;
            rData_r <= rdWord;
            rResp_r <= rdMapped ? osc_ctrl_pkg::RESP_OKAY : osc_ctrl_pkg::RESP_SLVERR;
        end else if (rValid_r && s_axi_rready) begin
            rValid_r <= 1'b0;
            arReady_r <= 1'b1;
        end
    end

    // Pin map write gate
    logic pinAccept_r;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pinAccept_r <= 1'b0;
        end else begin
            pinAccept_r <= pinMapWrReq && !pinLock_r;
        end
    end

    // Instruction tick at half rate, processor tick reduced by the ratio
    logic instr_r;
    logic proc_r;
    logic [6:0] dozeCnt_r;
    logic [6:0] dozeMask;
    assign dozeMask = redEn_r ? 7'((8'h01 << ratio_r) - 8'h01) : 7'h00;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            instr_r <= 1'b0;
            proc_r <= 1'b0;
            dozeCnt_r <= 7'h00;
        end else begin
            instr_r <= !instr_r;
            if (!instr_r) begin
                dozeCnt_r <= (dozeCnt_r + 7'h01) & dozeMask;
            end
            proc_r <= !instr_r && ((dozeCnt_r & dozeMask) == 7'h00);
        end
    end

    assign s_axi_awready = awReady_r;
    assign s_axi_wready = wReady_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = {16'h0000, rData_r};
    assign s_axi_rresp = rResp_r;
    assign pinMapWrAccept = pinAccept_r;
    assign currentSource = curSrc_r;
    assign secondaryOscEnable = secEn_r;
    assign pinMapLock = pinLock_r;
    assign pllCfg = '{outDiv: pllPost_r, prescale: pllPre_r, feedback: pllFb_r};
    assign rcCfg = '{rcPostscale: rcPost_r, rcTrim: trim_r};
    assign instrTick = instr_r;
    assign procTick = proc_r;
endmodule

// [bench/osc_ctrl_regs_assertions.sv]
// Port checker for the oscillator register block
`timescale 1ns/1ps
module osc_ctrl_regs_assertions (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic pinMapWrReq,
    input wire logic pinMapWrAccept,
    input wire logic pinMapLock,
    input wire logic secondaryOscEnable,
    input wire osc_ctrl_pkg::pll_cfg_t pllCfg,
    input wire osc_ctrl_pkg::rc_cfg_t rcCfg,
    input wire logic instrTick
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    AST_PIN_ACCEPT: assert property (pinMapWrAccept == $past(pinMapWrReq && !pinMapLock))
        else $error("pin map accept wrong");
    AST_LOCK_BY_BUS: assert property ($changed(pinMapLock) |-> s_axi_bvalid)
        else $error("pin map lock moved without write");
    AST_SEC_BY_BUS: assert property ($changed(secondaryOscEnable) |-> s_axi_bvalid)
        else $error("secondary enable moved without write");
    AST_POST_RSVD: assert property (pllCfg.outDiv != osc_ctrl_pkg::PLL_POST_RSVD)
        else $error("reserved divider code taken");
    AST_PLL_BY_BUS: assert property ($changed(pllCfg) |-> s_axi_bvalid)
        else $error("pll settings moved without write");
    AST_RC_BY_BUS: assert property ($changed(rcCfg) |-> s_axi_bvalid)
        else $error("rc settings moved without write");
    AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    // Skip the release edge, which still sees the reset value twice
    AST_TICK_TOGGLE: assert property (!$past(sys_rst) |-> instrTick != $past(instrTick))
        else $error("instruction tick did not toggle");
endmodule
bind osc_ctrl_regs osc_ctrl_regs_assertions osc_ctrl_regs_assertions_inst (.*);

// [bench/tb_top.sv]
// Self-checking bench for the oscillator register block
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
    logic mclk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pllLockedIn;
    logic pllTimerDoneIn, clockFailIn, muxAckIn, irqEvent, pinMapWrReq, pinMapWrAccept, muxReq;
    logic secondaryOscEnable, pinMapLock, instrTick, procTick;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, clockSwitchModeCfg, r;
    logic [2:0] initSourceCfg, currentSource, muxTarget;
    osc_ctrl_pkg::pll_cfg_t pllCfg;
    osc_ctrl_pkg::rc_cfg_t rcCfg;
    int failures = 0, num_checks = 0, cycles = 0, n;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r; logic [15:0] e;} row_t;
    row_t rows[8] = '{'{8'h04, 32'hFFFFFFFF, 2'h0, 16'hFFDF}, '{8'h04, 32'h80, 2'h0, 16'h00C0},
        '{8'h04, 32'h3040, 2'h0, 16'h3040}, '{8'h08, 32'hFFFFFFFF, 2'h0, 16'h01FF},
        '{8'h0C, 32'hFFFFFFFF, 2'h0, 16'h003F}, '{8'h0C, 32'h20, 2'h0, 16'h0020},
        '{8'h00, 32'hFFFF, 2'h2, 16'h2200}, '{8'h40, 32'hFFFF, 2'h2, 16'h0000}};
    logic [15:0] rstv[4] = '{16'h2200, 16'h3040, 16'h0030, 16'h0000};
    osc_ctrl_regs osc_ctrl_regs_inst (.*);
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    // Mux partner simply echoes the request one cycle late
    always @(posedge mclk) begin
        muxAckIn <= muxReq;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rv);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rv = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        dv = s_axi_rdata;
        rv = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {pllLockedIn, pllTimerDoneIn, clockFailIn, irqEvent, pinMapWrReq} = '0;
        s_axi_wstrb = 4'h3;
        initSourceCfg = 3'h2;
        clockSwitchModeCfg = 2'h0;
        sys_rst = 1'b1;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4), d, r);
            `CHK("reset value", rstv[i], d[15:0])
        end
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, r);
            `CHK("write response", rows[i].r, r)
            rd(rows[i].a, d, r);
            `CHK("read back", rows[i].e, d[15:0])
        end
        `CHK("pll outputs", 16'h41FF, pllCfg)
        `CHK("rc outputs", 9'h020, rcCfg)
        $display("test table done");
        pinMapWrReq <= 1'b1;
        wr(8'h04, 32'hB840, r);
        irqEvent <= 1'b1;
        @(posedge mclk);
        irqEvent <= 1'b0;
        `CHK("pin accept", 1'b1, pinMapWrAccept)
        rd(8'h04, d, r);
        `CHK("recovery", 16'hB040, d[15:0])
        $display("test recovery done");
        pllLockedIn <= 1'b1;
        clockFailIn <= 1'b1;
        wr(8'h10, 32'h5A3C, r);
        wr(8'h10, 32'hC3A5, r);
        wr(8'h00, 32'h014B, r);
        `CHK("unlocked write", osc_ctrl_pkg::RESP_OKAY, r)
        `CHK("secondary on", 1'b1, secondaryOscEnable)
        repeat (2) @(posedge mclk);
        `CHK("pin refused", 1'b0, pinMapWrAccept)
        for (n = 0; n < 200 && currentSource !== 3'h1; n++) @(posedge mclk);
        `CHK("current source", 3'h1, currentSource)
        `CHK("mux target", 3'h1, muxTarget)
        rd(8'h00, d, r);
        `CHK("switch status", 16'h116A, d[15:0])
        `CHK("fail flag", 1'b1, d[3])
        $display("test switch done");
        report_and_stop();
    end
endmodule
